// ---- src/bdc_config_regs.sv ----
/*
  Configuration bank of a full-bridge gate driver: six 10-bit registers
  written and read through whole serial frames, decoded into fields and
  cycle counts for the protection logic.
  Assumes a serial engine on ref_clk hands over each frame as a pulse
  and shifts out the answer word; status bits come from the same clock.
*/
`include "bdc_map.svh"
module bdc_config_regs
  import bdc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        frame_valid,
  input  wire bdc_frame_t  frame_data,
  input  wire logic [14:0] status_word,
  output logic             resp_valid,
  output bdc_frame_t       resp_data,
  output logic             frame_error,
  output logic [3:0]       overcurrent_verify_time,
  output logic [5:0]       dead_time_code,
  output logic [3:0]       overcurrent_threshold_code,
  output logic [5:0]       lowside_vds_threshold,
  output logic             overcurrent_qualifier_mode,
  output logic             vds_qualifier_mode,
  output logic [1:0]       bridge_disconnect_threshold,
  output logic [5:0]       highside_vds_threshold,
  output logic [3:0]       onstate_load_threshold,
  output logic [5:0]       vds_check_time,
  output logic             onstate_load_detect_enable,
  output logic             enable_input_watchdog,
  output logic             offstate_test_current_sel,
  output logic             gate_regulator_level,
  output logic [5:0]       phase_comparator_threshold,
  output logic             offstate_load_detect_off,
  output logic [3:0]       sense_offset_sel,
  output logic [2:0]       sense_gain_sel,
  output logic [11:0]      sense_offset_mv,
  output logic [5:0]       sense_gain_value,
  output logic             dead_time_enable,
  output logic [7:0]       dead_time_cycles,
  output logic [8:0]       oc_verify_cycles,
  output logic [8:0]       vds_check_cycles
);
  logic       rst_meta;
  logic       rst_sync;
  bdc_state_s st;
  bdc_state_s next_st;
  logic       frame_ok;
  logic [3:0] addr;
  logic       wr;
  bdc_cfg_t   wdata;
  bdc_cfg_t   rd_mux;
  bdc_frame_t resp_word;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // least time rounds up to whole clocks
  function automatic logic [9:0] ns_to_cycles(input logic [5:0] code, input int step_ns);
    int ns;
    ns = int'(code) * step_ns;
    return 10'((ns + `BDC_CLK_NS - 1) / `BDC_CLK_NS);
  endfunction

  function automatic bdc_cfg_t wmask(input logic [3:0] idx);
    return (idx == `BDC_IDX_SENSE) ? `BDC_MASK_SENSE : `BDC_MASK_FULL;
  endfunction

  function automatic bdc_cfg_t reset_val(input int idx);
    case (idx)
      0:       return `BDC_RST_TIMING;
      1:       return `BDC_RST_OC_LS;
      2:       return `BDC_RST_QUAL_HS;
      3:       return `BDC_RST_OL_VERIFY;
      4:       return `BDC_RST_LOAD_WD;
      default: return `BDC_RST_SENSE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // frame handling
  // ----------------------------------------------------------------
  bdc_frame_codec u_codec (
    .frame       (frame_data),
    .status_word (status_word),
    .read_data   (rd_mux),
    .frame_ok    (frame_ok),
    .addr        (addr),
    .wr          (wr),
    .wdata       (wdata),
    .resp_word   (resp_word)
  );

  // unmapped addresses answer with zero data
  assign rd_mux = (addr < 4'(`BDC_NUM_REGS)) ? st.cfg[addr[2:0]] : 10'h000;

  always_comb begin
    next_st             = st;
    next_st.resp_valid  = 1'b0;
    next_st.frame_error = 1'b0;
    if (frame_valid) begin
      next_st.resp_valid = 1'b1;
      next_st.resp_data  = resp_word;
      // a corrupted frame never reaches a register
      next_st.frame_error = !frame_ok;
      if (frame_ok && wr && addr < 4'(`BDC_NUM_REGS)) begin
        next_st.cfg[addr[2:0]] = wdata & wmask(addr);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int i = 0; i < `BDC_NUM_REGS; i++) begin
        st.cfg[i] <= reset_val(i);
      end
      st.resp_data   <= 16'h0000;
      st.resp_valid  <= 1'b0;
      st.frame_error <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign resp_valid  = st.resp_valid;
  assign resp_data   = st.resp_data;
  assign frame_error = st.frame_error;

  assign overcurrent_verify_time     = st.cfg[0][`BDC_F_HI4_HI:`BDC_F_HI4_LO];
  assign dead_time_code              = st.cfg[0][`BDC_F_LO6_HI:`BDC_F_LO6_LO];
  assign overcurrent_threshold_code  = st.cfg[1][`BDC_F_HI4_HI:`BDC_F_HI4_LO];
  assign lowside_vds_threshold       = st.cfg[1][`BDC_F_LO6_HI:`BDC_F_LO6_LO];
  assign overcurrent_qualifier_mode  = st.cfg[2][`BDC_F_BIT9];
  assign vds_qualifier_mode          = st.cfg[2][`BDC_F_BIT8];
  assign bridge_disconnect_threshold = st.cfg[2][`BDC_F_VTB_HI:`BDC_F_VTB_LO];
  assign highside_vds_threshold      = st.cfg[2][`BDC_F_LO6_HI:`BDC_F_LO6_LO];
  assign onstate_load_threshold      = st.cfg[3][`BDC_F_HI4_HI:`BDC_F_HI4_LO];
  assign vds_check_time              = st.cfg[3][`BDC_F_LO6_HI:`BDC_F_LO6_LO];
  assign onstate_load_detect_enable  = st.cfg[4][`BDC_F_BIT9];
  assign enable_input_watchdog       = st.cfg[4][`BDC_F_BIT8];
  assign offstate_test_current_sel   = st.cfg[4][`BDC_F_BIT7];
  assign gate_regulator_level        = st.cfg[4][`BDC_F_BIT6];
  assign phase_comparator_threshold  = st.cfg[4][`BDC_F_LO6_HI:`BDC_F_LO6_LO];
  assign offstate_load_detect_off    = st.cfg[5][`BDC_F_BIT8];
  assign sense_offset_sel            = st.cfg[5][`BDC_F_SAO_HI:`BDC_F_SAO_LO];
  assign sense_gain_sel              = st.cfg[5][`BDC_F_SAG_HI:`BDC_F_SAG_LO];

  always_comb begin
    case (sense_offset_sel)
      4'h0, 4'h1: sense_offset_mv = 12'h000;
      4'h2, 4'h3: sense_offset_mv = 12'h064;
      4'h4:       sense_offset_mv = 12'h0c8;
      4'h5:       sense_offset_mv = 12'h12c;
      4'h6:       sense_offset_mv = 12'h190;
      4'h7:       sense_offset_mv = 12'h1f4;
      4'h8:       sense_offset_mv = 12'h2ee;
      4'h9:       sense_offset_mv = 12'h3e8;
      4'ha:       sense_offset_mv = 12'h4e2;
      4'hb:       sense_offset_mv = 12'h5dc;
      4'hc:       sense_offset_mv = 12'h6d6;
      4'hd:       sense_offset_mv = 12'h7d0;
      4'he:       sense_offset_mv = 12'h8ca;
      default:    sense_offset_mv = 12'h9c4;
    endcase
  end

  // gain steps of five, top step ten
  assign sense_gain_value = (sense_gain_sel == 3'h7) ? 6'h32
                          : 6'(6'h0a + 6'(sense_gain_sel) * 6'h05);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  // zero disables, short codes floor
  assign dead_time_enable = (dead_time_code != 6'h00);
  assign dead_time_cycles = (dead_time_code == 6'h00) ? 8'h00
                          : (dead_time_code <= 6'h02)
                          ? 8'(ns_to_cycles(6'h01, `BDC_DT_MIN_NS))
                          : 8'(ns_to_cycles(dead_time_code, `BDC_DT_STEP_NS));
  assign oc_verify_cycles = 9'(ns_to_cycles(6'(overcurrent_verify_time), `BDC_OC_STEP_NS));
  assign vds_check_cycles = 9'(ns_to_cycles(vds_check_time, `BDC_VDS_STEP_NS));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync);

  property p_odd_answer;
    resp_valid |-> (^resp_data == 1'b1);
  endproperty
  a_odd_answer: assert property (p_odd_answer) else $error("answer parity even");

  property p_bad_frame_kept;
    frame_valid && !(^frame_data) |=> $stable(st.cfg) && frame_error;
  endproperty
  a_bad_frame_kept: assert property (p_bad_frame_kept) else $error("bad frame changed");

  property p_write_store;
    frame_valid && (^frame_data) && frame_data[11] && frame_data[15:12] == 4'h0
      |=> st.cfg[0] == $past(frame_data[10:1]);
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  property p_read_back;
    frame_valid && (^frame_data) && !frame_data[11] && frame_data[15:12] == 4'h3
      |=> resp_valid && resp_data[10:1] == $past(st.cfg[3])
      ##1 (!resp_valid || $past(frame_valid));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_unused_zero;
    st.cfg[5][9] == 1'b0 && st.cfg[5][3] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_oc_time;
    overcurrent_verify_time == 4'hf |-> oc_verify_cycles == 9'd375;
  endproperty
  a_oc_time: assert property (p_oc_time) else $error("verify count wrong");

  property p_dead_default;
    dead_time_code == 6'h20 |-> dead_time_cycles == 8'd80 && dead_time_enable;
  endproperty
  a_dead_default: assert property (p_dead_default) else $error("dead count wrong");

  property p_dead_short;
    dead_time_code inside {6'h01, 6'h02} |-> dead_time_cycles == 8'd5;
  endproperty
  a_dead_short: assert property (p_dead_short) else $error("short dead wrong");

  property p_vds_time;
    vds_check_time == 6'h3f |-> vds_check_cycles == 9'd315;
  endproperty
  a_vds_time: assert property (p_vds_time) else $error("check count wrong");

  property p_reset_vals;
    $rose(rst_sync) |-> gate_regulator_level && sense_gain_value == 6'd35
      && sense_offset_mv == 12'd2500 && !onstate_load_detect_enable;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

  // aliasing on addr[2:0] would corrupt a real register
  property p_unmapped_kept;
    frame_valid && (^frame_data) && frame_data[11] && frame_data[15:12] > 4'h5
      |=> $stable(st.cfg);
  endproperty
  a_unmapped_kept: assert property (p_unmapped_kept) else $error("unmapped write stored");

  property p_write_answer;
    frame_valid && (^frame_data) && frame_data[11]
      |=> resp_valid && resp_data[15:1] == $past(status_word);
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer wrong");

  property p_sense_masked;
    frame_valid && (^frame_data) && frame_data[11] && frame_data[15:12] == 4'h5
      |=> st.cfg[5] == ($past(frame_data[10:1]) & `BDC_MASK_SENSE);
  endproperty
  a_sense_masked: assert property (p_sense_masked) else $error("unused bit stored");

  property p_dead_zero;
    dead_time_code == 6'h00 |-> !dead_time_enable && dead_time_cycles == 8'h00;
  endproperty
  a_dead_zero: assert property (p_dead_zero) else $error("dead time not off");

  c_write: cover property (frame_valid && frame_ok && wr);
  c_read:  cover property (frame_valid && frame_ok && !wr ##1 resp_valid);
  c_bad:   cover property (frame_valid && !frame_ok);
  c_dead0: cover property (dead_time_code == 6'h00);
  c_unmap: cover property (frame_valid && frame_ok && wr && addr > 4'h5);
endmodule

// ---- src/bdc_map.svh ----
/*
  Register indices, field positions, reset values, frame layout and
  timing figures of the bridge driver configuration bank.
  Assumes a 50 MHz reference clock and 16-bit serial frames.
*/
// Functional notes
// - every frame holds an odd count of ones
// - verify time is code times 500 ns
// - dead time is code times 50 ns
// - codes 1,2 give 100 ns; zero disables
// - overcurrent threshold is (code+1) times 300 mV
// - low-side drain threshold is code times 50 mV
// - overcurrent qualifier: 0 debounce, 1 blanking
// - drain fault qualifier: 0 debounce, 1 blank
// - bridge disconnect is (code+1) times 2 V
// - high-side drain threshold is code times 50 mV
// - on-state load threshold (code+1) times 25 mV
// - drain check time is code times 100 ns
// - on-state load detect active when set
// - enable input watchdog active when set
// - test current 100 uA, 400 uA when set
// - regulator 8 V at 0, 13 V default
// - phase comparator threshold is code/64 of supply
// - offset code maps onto offset table, default 15
// - gain code maps onto gain table, default 35
// - write flag stores data, else returns contents
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define BDC_FRM_ADDR_HI   15
`define BDC_FRM_ADDR_LO   12
`define BDC_FRM_WR        11
`define BDC_FRM_DATA_HI   10
`define BDC_FRM_DATA_LO   1
`define BDC_FRM_PAR       0
`define BDC_NUM_REGS      6

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define BDC_IDX_TIMING    4'h0
`define BDC_IDX_OC_LS     4'h1
`define BDC_IDX_QUAL_HS   4'h2
`define BDC_IDX_OL_VERIFY 4'h3
`define BDC_IDX_LOAD_WD   4'h4
`define BDC_IDX_SENSE     4'h5

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define BDC_RST_TIMING    10'h3e0
`define BDC_RST_OC_LS     10'h258
`define BDC_RST_QUAL_HS   10'h018
`define BDC_RST_OL_VERIFY 10'h210
`define BDC_RST_LOAD_WD   10'h060
`define BDC_RST_SENSE     10'h0f5
`define BDC_MASK_FULL     10'h3ff
`define BDC_MASK_SENSE    10'h1f7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BDC_F_HI4_HI      9
`define BDC_F_HI4_LO      6
`define BDC_F_LO6_HI      5
`define BDC_F_LO6_LO      0
`define BDC_F_BIT9        9
`define BDC_F_BIT8        8
`define BDC_F_BIT7        7
`define BDC_F_BIT6        6
`define BDC_F_VTB_HI      7
`define BDC_F_VTB_LO      6
`define BDC_F_SAO_HI      7
`define BDC_F_SAO_LO      4
`define BDC_F_SAG_HI      2
`define BDC_F_SAG_LO      0

// ----------------------------------------------------------------
// timing figures in ns
// ----------------------------------------------------------------
`define BDC_CLK_NS        20
`define BDC_OC_STEP_NS    500
`define BDC_DT_STEP_NS    50
`define BDC_DT_MIN_NS     100
`define BDC_VDS_STEP_NS   100

`endif

// ---- src/bdc_pkg.sv ----
/*
  Types shared by the configuration bank and its frame codec.
  Fixes its own widths and register count; the map header supplies the rest.
*/
package bdc_pkg;
  typedef logic [9:0]  bdc_cfg_t;
  typedef logic [15:0] bdc_frame_t;

  typedef struct packed {
    bdc_cfg_t [5:0] cfg;
    bdc_frame_t     resp_data;
    logic           resp_valid;
    logic           frame_error;
  } bdc_state_s;
endpackage

// ---- src/bdc_frame_codec.sv ----
/*
  Frame codec: parity check and field split of an incoming frame, and
  assembly of the answer word with its parity bit.
  Assumes frames arrive whole from a serial engine on the same clock.
*/
`include "bdc_map.svh"
module bdc_frame_codec
  import bdc_pkg::*;
(
  input  wire bdc_frame_t  frame,
  input  wire logic [14:0] status_word,
  input  wire bdc_cfg_t    read_data,
  output logic             frame_ok,
  output logic [3:0]       addr,
  output logic             wr,
  output bdc_cfg_t         wdata,
  output bdc_frame_t       resp_word
);
  logic [14:0] body;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // odd count check
  assign frame_ok = ^frame;
  assign addr     = frame[`BDC_FRM_ADDR_HI:`BDC_FRM_ADDR_LO];
  assign wr       = frame[`BDC_FRM_WR];
  assign wdata    = frame[`BDC_FRM_DATA_HI:`BDC_FRM_DATA_LO];

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  // read returns contents
  assign body = (wr && frame_ok) ? status_word : {status_word[14:10], read_data};
  assign resp_word = {body, ~(^body)};
endmodule

// ---- test/bdc_host_model.sv ----
/*
  Host side of the configuration bank: sends whole frames and collects
  the answer on the falling edge half a cycle after the taking edge.
  Assumes the bank samples on the rising edge of ref_clk.
*/
module bdc_host_model
  import bdc_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            frame_valid,
  output bdc_frame_t      frame_data,
  input  wire logic       resp_valid,
  input  wire bdc_frame_t resp_data,
  input  wire logic       frame_error
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_valid = 1'b0;
    frame_data  = 16'h0000;
  end

  // ------------------------------------------------------------
  // one frame out, one answer back
  // ------------------------------------------------------------
  task automatic xfer(input logic [3:0] addr, input logic wr, input logic [9:0] data,
                      input logic bad_par, output logic got, output bdc_frame_t resp,
                      output logic err);
    logic [14:0] body;
    body = {addr, wr, data};
    @(negedge ref_clk);
    frame_valid = 1'b1;
    frame_data  = {body, ~^body ^ bad_par};
    @(negedge ref_clk);
    frame_valid = 1'b0;
    // stale bus never repeats the last frame
    frame_data  = ~frame_data;
    got  = resp_valid;
    resp = resp_data;
    err  = frame_error;
  endtask
endmodule

// ---- test/tb_top.sv ----
/*
  Self-checking bench of the configuration bank: reset values, write
  and read back, decoded counts and tables, refused frames.
  Assumes the host model in its own file and the shared map header.
*/
`include "bdc_map.svh"
module tb_top
  import bdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, rstn, frame_valid, frame_error, resp_valid;
  bdc_frame_t  frame_data, resp_data;
  logic [14:0] status_word;
  logic [3:0]  overcurrent_verify_time, overcurrent_threshold_code;
  logic [3:0]  onstate_load_threshold, sense_offset_sel;
  logic [5:0]  dead_time_code, lowside_vds_threshold, highside_vds_threshold;
  logic [5:0]  vds_check_time, phase_comparator_threshold, sense_gain_value;
  logic        overcurrent_qualifier_mode, vds_qualifier_mode, onstate_load_detect_enable;
  logic        enable_input_watchdog, offstate_test_current_sel, gate_regulator_level;
  logic        offstate_load_detect_off, dead_time_enable;
  logic [1:0]  bridge_disconnect_threshold;
  logic [2:0]  sense_gain_sel;
  logic [11:0] sense_offset_mv;
  logic [7:0]  dead_time_cycles;
  logic [8:0]  oc_verify_cycles, vds_check_cycles;
  int          num_errors, num_checks, cycles;
  logic        got, err;
  bdc_frame_t  resp;
  logic [9:0]  rst_val [6] = '{10'h3e0, 10'h258, 10'h018, 10'h210, 10'h060, 10'h0f5};
  logic [9:0]  mask_val [6] = '{10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h1f7};
  int          offs_mv [16] = '{0, 0, 100, 100, 200, 300, 400, 500, 750, 1000, 1250,
                                1500, 1750, 2000, 2250, 2500};
  int          gains [8] = '{10, 15, 20, 25, 30, 35, 40, 50};

  bdc_config_regs uut (.ref_clk, .rstn, .frame_valid, .frame_data, .status_word,
    .resp_valid, .resp_data, .frame_error, .overcurrent_verify_time, .dead_time_code,
    .overcurrent_threshold_code, .lowside_vds_threshold, .overcurrent_qualifier_mode,
    .vds_qualifier_mode, .bridge_disconnect_threshold, .highside_vds_threshold,
    .onstate_load_threshold, .vds_check_time, .onstate_load_detect_enable,
    .enable_input_watchdog, .offstate_test_current_sel, .gate_regulator_level,
    .phase_comparator_threshold, .offstate_load_detect_off, .sense_offset_sel,
    .sense_gain_sel, .sense_offset_mv, .sense_gain_value, .dead_time_enable,
    .dead_time_cycles, .oc_verify_cycles, .vds_check_cycles);

  bdc_host_model host (.ref_clk, .frame_valid, .frame_data, .resp_valid, .resp_data,
    .frame_error);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
      num_errors++;
    end
  endtask

  function automatic bdc_frame_t ans(input logic [9:0] d);
    ans = {status_word[14:10], d, ~^{status_word[14:10], d}};
  endfunction

  function automatic logic [9:0] fields(input int i);
    case (i)
      0: fields = {overcurrent_verify_time, dead_time_code};
      1: fields = {overcurrent_threshold_code, lowside_vds_threshold};
      2: fields = {overcurrent_qualifier_mode, vds_qualifier_mode,
                   bridge_disconnect_threshold, highside_vds_threshold};
      3: fields = {onstate_load_threshold, vds_check_time};
      4: fields = {onstate_load_detect_enable, enable_input_watchdog,
                   offstate_test_current_sel, gate_regulator_level, phase_comparator_threshold};
      default: fields = {1'b0, offstate_load_detect_off, sense_offset_sel, 1'b0, sense_gain_sel};
    endcase
  endfunction

  task automatic wr_chk(input int i, input logic [9:0] d);
    host.xfer(4'(i), 1'b1, d, 1'b0, got, resp, err);
    chk(16'({got, err}), 16'h0002);
    chk(resp, {status_word, ~^status_word});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      chk(16'(fields(i)), 16'(rst_val[i]));
      host.xfer(4'(i), 1'b0, 10'h000, 1'b0, got, resp, err);
      chk(resp, ans(rst_val[i]));
    end
    chk(16'(sense_offset_mv), 16'd2500);
    chk(16'(sense_gain_value), 16'd35);
    $display("test reset values done");
  endtask

  task automatic t_write();
    logic [9:0] pat [4] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa};
    for (int i = 0; i < 6; i++) begin
      foreach (pat[p]) begin
        wr_chk(i, pat[p]);
        chk(16'(fields(i)), 16'(pat[p] & mask_val[i]));
        host.xfer(4'(i), 1'b0, ~pat[p], 1'b0, got, resp, err);
        chk(resp, ans(pat[p] & mask_val[i]));
      end
    end
    $display("test write and read back done");
  endtask

  task automatic t_decode();
    for (int c = 0; c < 64; c++) begin
      wr_chk(0, {4'(c), 6'(c)});
      wr_chk(3, {4'h0, 6'(c)});
      chk(16'(dead_time_enable), 16'(c != 0));
      chk(16'(dead_time_cycles), (c == 0) ? 16'd0 : (c < 3) ? 16'd5 : 16'((c * 5 + 1) / 2));
      chk(16'(oc_verify_cycles), 16'((c % 16) * 25));
      chk(16'(vds_check_cycles), 16'(c * 5));
    end
    for (int c = 0; c < 16; c++) begin
      wr_chk(5, {2'b00, 4'(c), 1'b0, 3'(c)});
      chk(16'(sense_offset_mv), 16'(offs_mv[c]));
      chk(16'(sense_gain_value), 16'(gains[c % 8]));
    end
    $display("test decoded counts done");
  endtask

  task automatic t_refuse();
    host.xfer(4'h1, 1'b1, 10'h0a5, 1'b1, got, resp, err);
    chk(16'({got, err}), 16'h0003);
    chk(resp, ans(10'h2aa));
    chk(16'(fields(1)), 16'h02aa);
    for (int a = 6; a < 16; a++) begin
      wr_chk(a, 10'h3ff);
      host.xfer(4'(a), 1'b0, 10'h000, 1'b0, got, resp, err);
      chk(resp, ans(10'h000));
    end
    // unmapped writes must not alias onto the low registers
    chk(16'(fields(1)), 16'h02aa);
    chk(16'(fields(3)), 16'h003f);
    chk(16'(fields(5)), 16'h00f7);
    $display("test refused frames done");
  endtask

  // ------------------------------------------------------------
  // clock, reset, sequence, verdict
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ceiling well above the roughly 450 cycles the tests take
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    rstn        = 1'b0;
    status_word = 15'h6b3a;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    // internal reset lifts two edges after release
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_write();
    t_decode();
    t_refuse();
    end_sim();
  end
endmodule
